// *** cb_status_busnum_params.svh ***
// Constants for the secondary status and bus-number register bank.
// Assumes byte-addressed configuration space offsets, one function select bit.
`ifndef CB_STATUS_BUSNUM_PARAMS_SVH
`define CB_STATUS_BUSNUM_PARAMS_SVH

// ==========================================================
// Register offsets
`define OFS_SEC_STATUS       8'h16
`define OFS_UPSTREAM_BUS     8'h18
`define OFS_DOWNSTREAM_BUS   8'h19
`define OFS_HIGHEST_BUS      8'h1A

// ==========================================================
// Status bit positions
`define BIT_PARITY           15
`define BIT_SERR             14
`define BIT_MABORT           13
`define BIT_TA_RECEIVED      12
`define BIT_TA_SIGNALED      11
`define BIT_MASTER_DPAR      8

// ==========================================================
// Reset and fixed values
`define SEC_STATUS_RESET     16'h0200
`define SEC_STATUS_FIXED     16'h0200
`define BUSNUM_RESET         8'h00

`endif

// *** cb_status_busnum_pkg.sv ***
// Types for the secondary status and bus-number register bank.
// Assumes the constants header is available on the include path.
package cb_status_busnum_pkg;

  // Secondary-side error events, one-cycle pulses
  typedef struct packed {
    logic parity_error;
    logic card_serr;
    logic master_abort;
    logic target_abort_received;
    logic target_abort_signaled;
    logic cperr_seen;
    logic master_phase;
  } sec_event_t;

  // Configuration access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       func;
    logic [7:0] addr;
    logic [1:0] byte_en;
    logic [15:0] wdata;
  } cfg_req_t;

endpackage

// *** cardbus_secondary_status_busnum.sv ***
// Secondary status and bus-number registers of a two-function card bridge.
// Assumes config accesses arrive as single-cycle strobes on the core clock.
//
// Operation
// R1 - Writing one to a sticky status flag clears it.
// R2 - Bit 15 sets on secondary address or data parity error.
// R3 - Bit 14 sets when card asserts system error; bridge never drives it.
// R4 - Bit 13 sets when bridge-initiated cycle ends in master abort.
// R5 - Bit 12 sets when bridge-initiated cycle receives target abort.
// R6 - Bit 11 sets when bridge as target signals target abort.
// R7 - Bits 10 to 9 read constant 01, medium select timing.
// R8 - Bit 8 sets on error signal while master with parity response enabled.
// R9 - Bit 7 reads zero, no fast back-to-back.
// R10 - Bit 6 reads zero, no user-definable features.
// R11 - Bit 5 reads zero, clock at most 33 MHz.
// R12 - Bits 4 to 0 read zero.
// R13 - Status reads 0200 hex after reset.
// R14 - Upstream bus register, reset zero, used for forwarding.
// R15 - Downstream bus register, reset zero, combined for forwarding.
// R16 - Highest downstream bus register, reset zero, bounds forwarding.
// R17 - Downstream and highest bus numbers kept per socket function.
// R18 - Forward downstream only when target bus lies within downstream..highest.
// R19 - Writing zero or writing read-only bits leaves them unchanged.
`include "cb_status_busnum_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cardbus_secondary_status_busnum #(
  parameter int NUM_FUNCS = 2
) (
  input  wire logic                              core_clk_in,
  input  wire logic                              rstn_in,
  input  wire cb_status_busnum_pkg::cfg_req_t    cfg_req_in,
  output logic [15:0]                            cfg_rdata_out,
  input  wire cb_status_busnum_pkg::sec_event_t  sec_event_in [NUM_FUNCS],
  input  wire logic [NUM_FUNCS-1:0]              parity_response_en_in,
  input  wire logic                              fwd_func_in,
  input  wire logic [7:0]                        fwd_target_bus_in,
  output logic                                   fwd_downstream_out,
  output logic                                   fwd_local_out,
  output logic                                   card_serr_oe_out
);
  import cb_status_busnum_pkg::*;

  // Elaboration check: the function select is one bit wide, so only two copies can be reached
  if (NUM_FUNCS != 2)
  begin : g_bad_num_funcs
    $error("NUM_FUNCS must be 2");
  end

  // ==========================================================
  // Address decode
  wire hit_status = cfg_req_in.addr == `OFS_SEC_STATUS;
  wire hit_up     = cfg_req_in.addr == `OFS_UPSTREAM_BUS;
  wire hit_down   = cfg_req_in.addr == `OFS_DOWNSTREAM_BUS;
  wire hit_high   = cfg_req_in.addr == `OFS_HIGHEST_BUS;
  wire [15:0] wmask = {{8{cfg_req_in.byte_en[1]}}, {8{cfg_req_in.byte_en[0]}}};
  wire [15:0] clr_bits = (cfg_req_in.wr && hit_status) ? (cfg_req_in.wdata & wmask) : 16'h0000;

  // Never drive the card's system error line
  assign card_serr_oe_out = 1'b0; // [R3]

  logic [7:0] upstream_bus_number; // Shared by both functions
  logic [7:0] downstream_bus_number [NUM_FUNCS];
  logic [7:0] highest_downstream_bus_number [NUM_FUNCS];
  logic [4:0] sticky [NUM_FUNCS]; // {15,14,13,12,11}
  logic       dpar [NUM_FUNCS];

  // Upstream bus number, written only through its byte lane
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      upstream_bus_number <= `BUSNUM_RESET; // [R14]
    else if (cfg_req_in.wr && hit_up && cfg_req_in.byte_en[0])
      upstream_bus_number <= cfg_req_in.wdata[7:0]; // [R14]
  end

  // ==========================================================
  // Per-function copies
  genvar f;
  generate
    for (f = 0; f < NUM_FUNCS; f++)
    begin : g_func
      wire sel = cfg_req_in.func == 1'(f);
      wire [4:0] set_bits = {sec_event_in[f].parity_error,          // [R2]
                             sec_event_in[f].card_serr,             // [R3]
                             sec_event_in[f].master_abort,          // [R4]
                             sec_event_in[f].target_abort_received, // [R5]
                             sec_event_in[f].target_abort_signaled}; // [R6]
      wire [4:0] clr = sel ? clr_bits[`BIT_PARITY:`BIT_TA_SIGNALED] : 5'h00;
      wire set_dpar = sec_event_in[f].cperr_seen && sec_event_in[f].master_phase
                      && parity_response_en_in[f]; // [R8]
      wire clr_dpar = sel && clr_bits[`BIT_MASTER_DPAR];
      wire [4:0] next_sticky = set_bits | (sticky[f] & ~clr); // Set beats clear [R1] [R19]

      always_ff @(posedge core_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          sticky[f] <= 5'h00; // [R13]
          dpar[f]   <= 1'b0;
        end
        else
        begin
          sticky[f] <= next_sticky;
          dpar[f]   <= set_dpar | (dpar[f] & ~clr_dpar); // [R1] [R8]
        end
      end

      // Bus numbers held separately per socket function
      always_ff @(posedge core_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          downstream_bus_number[f]         <= `BUSNUM_RESET; // [R15]
          highest_downstream_bus_number[f] <= `BUSNUM_RESET; // [R16]
        end
        else if (cfg_req_in.wr && sel && cfg_req_in.byte_en[0])
        begin
          if (hit_down)
            downstream_bus_number[f] <= cfg_req_in.wdata[7:0]; // [R17]
          else if (hit_high)
            highest_downstream_bus_number[f] <= cfg_req_in.wdata[7:0]; // [R17]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read-back assembly; fixed bits come from a constant
  wire        rf = cfg_req_in.func;
  wire [15:0] status_view = `SEC_STATUS_FIXED // [R7] [R9] [R10] [R11] [R12]
                          | {sticky[rf], 2'b00, dpar[rf], 8'h00};
  wire [15:0] next_rdata = !cfg_req_in.rd ? cfg_rdata_out
                         : hit_status ? status_view
                         : hit_up     ? {8'h00, upstream_bus_number}
                         : hit_down   ? {8'h00, downstream_bus_number[rf]}
                         : hit_high   ? {8'h00, highest_downstream_bus_number[rf]}
                         : 16'h0000;

  // Read data registered one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cfg_rdata_out <= 16'h0000;
    else
      cfg_rdata_out <= next_rdata;
  end

  // ==========================================================
  // Forwarding decision, registered
  wire [7:0] lo = downstream_bus_number[fwd_func_in];
  wire [7:0] hi = highest_downstream_bus_number[fwd_func_in];
  wire next_fwd_down  = (fwd_target_bus_in >= lo) && (fwd_target_bus_in <= hi); // [R18] [R15] [R16]
  wire next_fwd_local = fwd_target_bus_in == upstream_bus_number; // [R14]

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fwd_downstream_out <= 1'b0;
      fwd_local_out      <= 1'b0;
    end
    else
    begin
      fwd_downstream_out <= next_fwd_down;
      fwd_local_out      <= next_fwd_local;
    end
  end

endmodule // cardbus_secondary_status_busnum

`default_nettype wire

// *** cb_card_model.sv ***
// Card-side model: turns a bench command into error pulses.
// Assumes commands change just after the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module cb_card_model (
  input  wire logic                        clk_in,
  input  wire logic [6:0]                  pattern_in,
  input  wire logic [1:0]                  func_mask_in,
  output cb_status_busnum_pkg::sec_event_t event_out [2]
);
  import cb_status_busnum_pkg::*;
  // ==========
  // Pulses
  // Registered, so each pulse follows its command one cycle later and lasts as long as the command
  always_ff @(posedge clk_in)
    for (int f = 0; f < 2; f++)
      event_out[f] <= func_mask_in[f] ? sec_event_t'(pattern_in) : '0;
endmodule // cb_card_model
`default_nettype wire

// *** cardbus_secondary_status_busnum_props.sv ***
// Checker for the status and bus-number bank, top ports only.
// Assumes one clock and the async low reset; bound below.
`timescale 1ns/10ps
`default_nettype none
module cardbus_secondary_status_busnum_props #(parameter int NUM_FUNCS = 2) (
  input wire logic                             core_clk_in,
  input wire logic                             rstn_in,
  input wire cb_status_busnum_pkg::cfg_req_t   cfg_req_in,
  input wire logic [15:0]                      cfg_rdata_out,
  input wire cb_status_busnum_pkg::sec_event_t sec_event_in [NUM_FUNCS],
  input wire logic [NUM_FUNCS-1:0]             parity_response_en_in,
  input wire logic                             fwd_func_in,
  input wire logic [7:0]                       fwd_target_bus_in,
  input wire logic                             fwd_downstream_out,
  input wire logic                             fwd_local_out,
  input wire logic                             card_serr_oe_out
);
  import cb_status_busnum_pkg::*;
  // ==========
  // Decode; status accesses function 0 only, upstream accesses either function
  wire st_rd = cfg_req_in.rd && cfg_req_in.addr == 8'h16 && !cfg_req_in.func;
  wire st_wr = cfg_req_in.wr && cfg_req_in.addr == 8'h16 && !cfg_req_in.func && cfg_req_in.byte_en[1];
  wire par   = sec_event_in[0].parity_error;
  wire up_wr = cfg_req_in.wr && cfg_req_in.addr == 8'h18 && cfg_req_in.byte_en[0];
  wire up_rd = cfg_req_in.rd && cfg_req_in.addr == 8'h18;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========
  // Properties
  AST_SERR_OE: assert property (card_serr_oe_out == 1'b0)
    else $error("card error line driven");
  AST_FIXED: assert property (st_rd |=> {cfg_rdata_out[10:9], cfg_rdata_out[7:0]} == 10'h100)
    else $error("fixed status bits wrong");
  AST_PARITY: assert property (par ##1 st_rd |=> cfg_rdata_out[15])
    else $error("parity flag missing");
  AST_SERR: assert property (sec_event_in[0].card_serr ##1 st_rd |=> cfg_rdata_out[14])
    else $error("system error flag missing");
  AST_DPAR: assert property (sec_event_in[0].cperr_seen && sec_event_in[0].master_phase
    && parity_response_en_in[0] ##1 st_rd |=> cfg_rdata_out[8])
    else $error("data parity flag missing");
  AST_CLEAR: assert property (st_wr && cfg_req_in.wdata[15] && !par ##1 st_rd |=> !cfg_rdata_out[15])
    else $error("parity flag not cleared");
  AST_UPSTREAM: assert property (up_wr ##1 up_rd |=> cfg_rdata_out[7:0] == $past(cfg_req_in.wdata[7:0], 2))
    else $error("upstream bus readback wrong");
  AST_HOLD: assert property (!cfg_req_in.rd |=> $stable(cfg_rdata_out))
    else $error("read data moved without read");
endmodule // cardbus_secondary_status_busnum_props
bind cardbus_secondary_status_busnum cardbus_secondary_status_busnum_props #(.NUM_FUNCS(NUM_FUNCS)) props_i (
  .core_clk_in, .rstn_in, .cfg_req_in, .cfg_rdata_out, .sec_event_in, .parity_response_en_in,
  .fwd_func_in, .fwd_target_bus_in, .fwd_downstream_out, .fwd_local_out, .card_serr_oe_out);
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the status and bus-number bank.
// Assumes the card model drives the secondary event inputs.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cb_status_busnum_pkg::*;
  typedef struct {logic f; logic [7:0] a, d; logic [15:0] e; logic [7:0] t; logic dn, lc;} row_t;
  logic       clk = 0, rstn = 0, fwd_f = 0, dn, lc, oe;
  logic [1:0] pren = 2'h1, fn = 2'h0;
  logic [6:0] ev = 7'h00;
  logic [7:0] tgt = 8'h00;
  logic [15:0] rdat, m;
  cfg_req_t   req = '0;
  sec_event_t evs [2];
  int         failures = 0, num_checks = 0;
  row_t rows [8] = '{'{0,8'h18,8'h5A,16'h005A,8'h5A,0,1}, '{0,8'h19,8'h10,16'h0010,8'h0F,0,0},
    '{0,8'h1A,8'h20,16'h0020,8'h10,1,0}, '{0,8'h17,8'hFF,16'h0000,8'h20,1,0},
    '{0,8'h1B,8'hFF,16'h0000,8'h21,0,0}, '{1,8'h19,8'h40,16'h0040,8'h40,0,0},
    '{1,8'h1A,8'h44,16'h0044,8'h44,1,0}, '{1,8'h18,8'h5A,16'h005A,8'h3F,0,0}};
  cardbus_secondary_status_busnum cardbus_secondary_status_busnum_i (.core_clk_in(clk), .rstn_in(rstn),
    .cfg_req_in(req), .cfg_rdata_out(rdat), .sec_event_in(evs), .parity_response_en_in(pren),
    .fwd_func_in(fwd_f), .fwd_target_bus_in(tgt), .fwd_downstream_out(dn), .fwd_local_out(lc),
    .card_serr_oe_out(oe));
  cb_card_model cb_card_model_i (.clk_in(clk), .pattern_in(ev), .func_mask_in(fn), .event_out(evs));
  // ==========
  // Tasks
  always #5 clk = ~clk;
  task chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request stays up on return so back-to-back calls never double-drive
  task acc(input logic w, f, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    req <= '{rd: !w, wr: w, func: f, addr: a, byte_en: be, wdata: d};
    @(posedge clk) #1;
  endtask
  task fire(input logic [6:0] p, input logic [1:0] fm);
    ev <= p;
    fn <= fm;
    @(posedge clk) #1 ev <= 7'h00;
    @(posedge clk) #1;
  endtask
  task do_reset;
    rstn <= 0;
    req <= '0;
    repeat (8) @(posedge clk) #1;
    chk("reset rdata", rdat, 16'h0000);
    rstn <= 1;
    acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("status reset", rdat, 16'h0200);
    acc(0, 0, 8'h18, 2'h3, 16'h0000); chk("upstream reset", rdat, 16'h0000);
    acc(0, 1, 8'h19, 2'h3, 16'h0000); chk("downstream reset", rdat, 16'h0000);
    acc(0, 1, 8'h1A, 2'h3, 16'h0000); chk("highest reset", rdat, 16'h0000);
    $display("reset test done");
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Sequence
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      fwd_f <= rows[i].f;
      tgt <= rows[i].t;
      acc(1, rows[i].f, rows[i].a, 2'h3, {8'h00, rows[i].d});
      acc(0, rows[i].f, rows[i].a, 2'h3, 16'h0000);
      chk("bus read", rdat, rows[i].e);
      chk("forward", {15'h0000, dn}, {15'h0000, rows[i].dn});
      chk("local", {15'h0000, lc}, {15'h0000, rows[i].lc});
    end
    acc(0, 0, 8'h19, 2'h3, 16'h0000); chk("func0 copy kept", rdat, 16'h0010);
    $display("row test done");
    for (int b = 2; b < 7; b++)
    begin
      m = 16'h0200 | (16'h0001 << (9 + b));
      fire(7'h01 << b, 2'h1);
      acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("status set", rdat, m);
      acc(0, 1, 8'h16, 2'h3, 16'h0000); chk("other status", rdat, 16'h0200);
      acc(1, 0, 8'h16, 2'h3, ~m);
      acc(1, 0, 8'h16, 2'h1, m);
      acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("status kept", rdat, m);
      acc(1, 0, 8'h16, 2'h2, m);
      acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("status cleared", rdat, 16'h0200);
    end
    $display("event test done");
    pren <= 2'h0;
    fire(7'h03, 2'h3);
    acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("dpar no enable", rdat, 16'h0200);
    pren <= 2'h1;
    fire(7'h02, 2'h1);
    acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("dpar not master", rdat, 16'h0200);
    fire(7'h03, 2'h1);
    acc(0, 0, 8'h16, 2'h3, 16'h0000); chk("dpar set", rdat, 16'h0300);
    chk("card error drive", {15'h0000, oe}, 16'h0000);
    $display("parity test done");
    do_reset();
    tally_and_finish();
  end
  // Watchdog, far beyond the roughly 90 cycles the tests need
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
